// File: logic/rci_remote_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "rci_defines.svh"

// What this block does
// - Degas starts on validated falling request edge
// - Degas needs filament on, gate low, lockout high
// - Degas ends itself after three minutes
// - Degas ends on release, filament off, lockout
// - Lockout low forces filament off, refuses on
// - Lockout high allows normal filament operation
// - Lockout level acts after 50 ms stable
// - Keypad inhibit blocks on keys, not off
// - Keypad inhibit never touches power button
// - Keypad inhibit needs no prerequisites
// - Validated log clear fall clears data log
// - Remote gate high ignores degas, filament, lockout
// - Unconnected gate reads high, remote disabled
// - Validated filament request fall turns filament on
// - Validated filament request rise turns filament off
// - Panel lock low ignores all panel input
// - Panel lock high allows normal panel use
// - Edge valid after full stable debounce time
module rci_remote_ctrl #(
  parameter int unsigned DEB_CYC = `RCI_DEBOUNCE_CYC,
  parameter longint unsigned DEGAS_CYC = `RCI_DEGAS_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Active-low remote lines from the connector
  input wire rci_pkg::rci_lines_t lines_n_i,
  // Controller state and panel or host requests
  input wire logic filament_on_i,
  input wire rci_pkg::rci_panel_s panel_i,
  // Filtered requests toward the controller
  output rci_pkg::rci_grant_s grant_o,
  // Remote actions, one-cycle pulses; fil_off_o repeats every cycle under lockout while filament is on
  output logic degas_start_o,
  output logic degas_stop_o,
  output logic fil_on_o,
  output logic fil_off_o,
  output logic log_clear_o,
  // Level flags
  output logic degas_active_o,
  output logic fil_locked_o,
  output logic keypad_inhibit_o,
  output logic panel_locked_o,
  output logic remote_enabled_o
);
  import rci_pkg::*;

  rci_lines_t lvl;
  rci_lines_t rise;
  rci_lines_t fall;

  // One filter per line; all lines share the debounce time
  for (genvar g = 0; g < `RCI_NLINES; g++)
  begin : g_line
    rci_debounce #(
      .DEB_CYC(DEB_CYC)
    ) u_deb (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .pin_i(lines_n_i[g]),
      .level_o(lvl[g]),
      .rise_o(rise[g]),
      .fall_o(fall[g])
    );
  end

  typedef struct packed {
    rci_degas_e dg;
    logic dg_act;
    logic [63:0] dg_cnt;
    rci_grant_s grant;
    logic dg_start;
    logic dg_stop;
    logic fil_on;
    logic fil_off;
    logic log_clr;
    logic locked;
    logic keyinh;
    logic panel;
    logic remote;
  } rci_st_s;

  rci_st_s st_r;
  rci_st_s st_nxt;

  logic remote_ok;
  logic lock_eff;
  logic dg_ok;
  logic dg_end;

  // Remote edges count only while the gate is low; gated edges are lost, not replayed
  function automatic logic remote_edge(input logic gate_ok, input logic edge_seen);
    return gate_ok & edge_seen;
  endfunction

  // Gate high (also when unconnected) masks the remote functions
  assign remote_ok = ~lvl[`RCI_LN_GATE];
  // Lockout is honoured only while remote is enabled; high means normal
  assign lock_eff = remote_ok & ~lvl[`RCI_LN_LOCKOUT];
  assign dg_ok = filament_on_i & remote_ok & lvl[`RCI_LN_LOCKOUT];

  // Ending causes for a running degas
  always_comb
  begin
    dg_end = 1'b0;
    if (st_r.dg_cnt >= DEGAS_CYC - 64'h1)
    begin
      dg_end = 1'b1;
    end
    if (!filament_on_i || lock_eff || st_r.fil_off)
    begin
      dg_end = 1'b1;
    end
    if (remote_edge(remote_ok, rise[`RCI_LN_DEGAS]))
    begin
      dg_end = 1'b1;
    end
  end

  // Next state of actions, flags and the request filter
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.dg_start = 1'b0;
    st_nxt.dg_stop = 1'b0;
    st_nxt.fil_on = 1'b0;
    st_nxt.fil_off = 1'b0;
    st_nxt.log_clr = fall[`RCI_LN_LOGCLR];
    st_nxt.remote = remote_ok;
    st_nxt.locked = lock_eff;
    st_nxt.keyinh = ~lvl[`RCI_LN_KEYINH];
    st_nxt.panel = ~lvl[`RCI_LN_PANEL];
    // Filament request edges
    if (remote_edge(remote_ok, fall[`RCI_LN_FILREQ]) && lvl[`RCI_LN_LOCKOUT])
    begin
      st_nxt.fil_on = 1'b1;
    end
    if (remote_edge(remote_ok, rise[`RCI_LN_FILREQ]) || (lock_eff && filament_on_i))
    begin
      st_nxt.fil_off = 1'b1;
    end
    // Degas sequence
    unique case (st_r.dg)
      RCI_DG_IDLE:
      begin
        st_nxt.dg_cnt = 64'h0;
        if (fall[`RCI_LN_DEGAS] && dg_ok)
        begin
          st_nxt.dg = RCI_DG_RUN;
          st_nxt.dg_start = 1'b1;
        end
      end
      RCI_DG_RUN:
      begin
        st_nxt.dg_cnt = st_r.dg_cnt + 64'h1;
        if (dg_end)
        begin
          st_nxt.dg = RCI_DG_IDLE;
          st_nxt.dg_stop = 1'b1;
        end
      end
      default:
      begin
        st_nxt.dg = RCI_DG_IDLE;
      end
    endcase
    // Registered copy of the run state so the output needs no decode
    st_nxt.dg_act = (st_nxt.dg == RCI_DG_RUN);
    // Panel and host request filter; panel lock wins over keypad inhibit
    st_nxt.grant = panel_i;
    if (~lvl[`RCI_LN_PANEL])
    begin
      st_nxt.grant.fil_on_key = 1'b0;
      st_nxt.grant.fil_off_key = 1'b0;
      st_nxt.grant.mult_on_key = 1'b0;
      st_nxt.grant.mult_off_key = 1'b0;
      st_nxt.grant.power_key = 1'b0;
      st_nxt.grant.touch = 1'b0;
    end
    else if (~lvl[`RCI_LN_KEYINH])
    begin
      // Off keys and power stay usable
      st_nxt.grant.fil_on_key = 1'b0;
      st_nxt.grant.mult_on_key = 1'b0;
    end
    if (lock_eff)
    begin
      st_nxt.grant.fil_on_key = 1'b0;
      st_nxt.grant.fil_on_host = 1'b0;
    end
  end

  // Single register stage; all outputs come from here
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign grant_o = st_r.grant;
  assign degas_start_o = st_r.dg_start;
  assign degas_stop_o = st_r.dg_stop;
  assign fil_on_o = st_r.fil_on;
  assign fil_off_o = st_r.fil_off;
  assign log_clear_o = st_r.log_clr;
  assign degas_active_o = st_r.dg_act;
  assign fil_locked_o = st_r.locked;
  assign keypad_inhibit_o = st_r.keyinh;
  assign panel_locked_o = st_r.panel;
  assign remote_enabled_o = st_r.remote;

  chk_degas_prereq: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    degas_start_o |-> $past(filament_on_i) && $past(remote_ok) && $past(lvl[`RCI_LN_LOCKOUT]))
  else $error("degas started without prerequisites");
  chk_degas_edge: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    degas_start_o |-> $past(fall[`RCI_LN_DEGAS]))
  else $error("degas started without a validated falling edge");
  chk_degas_lock: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && degas_active_o && lock_eff) |=> !degas_active_o)
  else $error("degas kept running under lockout");
  chk_gate_blocks: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && !remote_ok) |=> !fil_on_o && !degas_start_o)
  else $error("remote action taken while gate high");
  chk_lock_host: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && lock_eff) |=> !grant_o.fil_on_host && !grant_o.fil_on_key)
  else $error("filament on granted under lockout");
  chk_keyinh_off: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && lvl[`RCI_LN_PANEL] && panel_i.fil_off_key) |=> grant_o.fil_off_key)
  else $error("filament off key blocked");
  chk_power_key: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && lvl[`RCI_LN_PANEL]) |=> grant_o.power_key == $past(panel_i.power_key))
  else $error("power key altered by keypad inhibit");
  chk_panel_lock: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && !lvl[`RCI_LN_PANEL]) |=> !grant_o.power_key && !grant_o.touch)
  else $error("panel input passed while locked");
  chk_log_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && fall[`RCI_LN_LOGCLR]) |=> log_clear_o ##1 (!log_clear_o || $past(fall[3])))
  else $error("log clear pulse wrong");

  // Degas timing, lockout and key masking
  chk_degas_timeout: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && degas_active_o && st_r.dg_cnt >= DEGAS_CYC - 64'h1) |=> !degas_active_o)
  else $error("degas ran past its period");
  chk_start_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && degas_start_o) |=> !degas_start_o)
  else $error("degas start longer than one cycle");
  chk_stop_pulse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && degas_stop_o) |=> !degas_stop_o)
  else $error("degas stop longer than one cycle");
  chk_lock_filoff: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && lock_eff && filament_on_i) |=> fil_off_o)
  else $error("filament not switched off under lockout");
  chk_lock_refuse: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && lock_eff) |=> !fil_on_o)
  else $error("remote filament on accepted under lockout");
  chk_keyinh_mult: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && !lvl[`RCI_LN_KEYINH]) |=> !grant_o.mult_on_key && !grant_o.fil_on_key)
  else $error("on key passed while keypad inhibited");
  chk_panel_free: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && lvl[`RCI_LN_PANEL] && lvl[`RCI_LN_KEYINH] && !lock_eff)
    |=> grant_o == $past(panel_i))
  else $error("panel input altered while free");

  // Level flags track the filtered lines one cycle later; state holds while ce_i is low
  chk_remote_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i |=> remote_enabled_o == $past(remote_ok))
  else $error("remote enabled flag wrong");
  chk_locked_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i |=> fil_locked_o == $past(lock_eff))
  else $error("filament locked flag wrong");
  chk_keyinh_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i |=> keypad_inhibit_o == !$past(lvl[`RCI_LN_KEYINH]))
  else $error("keypad inhibit flag wrong");
  chk_panel_flag: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ce_i |=> panel_locked_o == !$past(lvl[`RCI_LN_PANEL]))
  else $error("panel locked flag wrong");
  chk_ce_freeze: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !ce_i |=> $stable(grant_o) && $stable(degas_active_o) && $stable(fil_locked_o))
  else $error("state moved while clock enable low");

  // Main scenarios the bench must reach
  cov_degas_run: cover property (@(posedge ref_clk_i) degas_start_o);
  cov_degas_stop: cover property (@(posedge ref_clk_i) degas_stop_o);
  cov_fil_on: cover property (@(posedge ref_clk_i) fil_on_o);
  cov_log_clear: cover property (@(posedge ref_clk_i) log_clear_o);
  cov_lockout_off: cover property (@(posedge ref_clk_i) fil_locked_o && fil_off_o);

endmodule
`default_nettype wire

// File: pkg/rci_defines.svh
`ifndef RCI_DEFINES_SVH
`define RCI_DEFINES_SVH

// Debounce and degas timing
`define RCI_CLK_HZ 125000000
`define RCI_DEBOUNCE_MS 50
`define RCI_DEGAS_MIN 3
`define RCI_DEBOUNCE_CYC ((`RCI_CLK_HZ / 1000) * `RCI_DEBOUNCE_MS)
`define RCI_DEGAS_CYC (64'(`RCI_CLK_HZ) * 60 * `RCI_DEGAS_MIN)

// Line positions in the synchronised input vector
`define RCI_LN_DEGAS 0
`define RCI_LN_LOCKOUT 1
`define RCI_LN_KEYINH 2
`define RCI_LN_LOGCLR 3
`define RCI_LN_GATE 4
`define RCI_LN_FILREQ 5
`define RCI_LN_PANEL 6
`define RCI_NLINES 7

// Unconnected lines read high, so all lines idle high
`define RCI_LINES_IDLE 7'h7f

`endif

// File: pkg/rci_pkg.sv
package rci_pkg;

  typedef logic [6:0] rci_lines_t;

  // Front panel and host requests that the block filters
  typedef struct packed {
    logic fil_on_key;
    logic fil_off_key;
    logic mult_on_key;
    logic mult_off_key;
    logic power_key;
    logic touch;
    logic fil_on_host;
  } rci_panel_s;

  // Filtered requests toward the controller
  typedef struct packed {
    logic fil_on_key;
    logic fil_off_key;
    logic mult_on_key;
    logic mult_off_key;
    logic power_key;
    logic touch;
    logic fil_on_host;
  } rci_grant_s;

  typedef enum logic [1:0] {
    RCI_DG_IDLE,
    RCI_DG_RUN
  } rci_degas_e;

endpackage

// File: logic/rci_debounce.sv
`timescale 1ns/100ps
`default_nettype none
`include "rci_defines.svh"

// Two-stage synchroniser plus stable-time filter for one line
module rci_debounce #(
  parameter int unsigned DEB_CYC = `RCI_DEBOUNCE_CYC
) (
  // Clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Raw pin and filtered result
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);
  import rci_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic rise;
    logic fall;
    logic [31:0] cnt;
  } rci_deb_s;

  rci_deb_s st_r;
  rci_deb_s st_nxt;

  // Count only while the synced line differs from the accepted level
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rise = 1'b0;
    st_nxt.fall = 1'b0;
    st_nxt.s1 = pin_i;
    st_nxt.s2 = st_r.s1;
    if (st_r.s2 == st_r.lvl)
    begin
      st_nxt.cnt = 32'h0;
    end
    else if (st_r.cnt >= 32'(DEB_CYC - 1))
    begin
      // New level held for the full debounce time
      st_nxt.cnt = 32'h0;
      st_nxt.lvl = st_r.s2;
      st_nxt.rise = st_r.s2;
      st_nxt.fall = ~st_r.s2;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + 32'h1;
    end
  end

  // Idle high matches an unconnected line
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      st_r <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, rise: 1'b0, fall: 1'b0, cnt: 32'h0};
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
    end
  end

  assign level_o = st_r.lvl;
  assign rise_o = st_r.rise;
  assign fall_o = st_r.fall;

  chk_level_stable: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (ce_i && st_r.lvl != $past(st_r.lvl)) |-> $past(st_r.s2) == st_r.lvl)
  else $error("debounced level changed to a value not seen on the line");

endmodule
`default_nettype wire

// File: dv/rci_far_end.sv
`timescale 1ns/100ps
`default_nettype none

// Far-side logic or relay contacts driving the active-low remote lines
module rci_far_end #(
  parameter int HOLD = 12
) (
  // Clock and driven lines
  input wire logic ref_clk_i,
  output logic [6:0] lines_n_o
);
  int cyc = 0;
  int last [7] = '{default: 0};

  // Open lines read high, so every line idles high
  initial lines_n_o = 7'h7f;

  // Cycle count used to keep each level long enough
  always @(negedge ref_clk_i) cyc <= cyc + 1;

  // A new level waits until the old one was held HOLD cycles, then holds
  task automatic set_line(input int idx, input logic val);
    while (cyc - last[idx] < HOLD) @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    lines_n_o[idx] = val;
    last[idx] = cyc;
  endtask

  // Short spike that breaks the hold time on purpose
  task automatic glitch(input int idx, input int n);
    @(negedge ref_clk_i);
    lines_n_o[idx] = ~lines_n_o[idx];
    repeat (n) @(negedge ref_clk_i);
    lines_n_o[idx] = ~lines_n_o[idx];
  endtask
endmodule

`default_nettype wire

// File: dv/remote_control_input_logic_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module remote_control_input_logic_tb_top;
  import rci_pkg::*;
  localparam int P_START = 4;
  localparam int P_STOP = 3;
  localparam int P_FON = 2;
  localparam int P_FOFF = 1;
  localparam int P_LOG = 0;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic filament_on_i = 1'b0;
  logic ce_i = 1'b1;
  rci_panel_s panel_i = '1;
  rci_grant_s grant_o;
  rci_lines_t lines_n;
  logic [4:0] pulses;
  logic degas_active_o;
  logic fil_locked_o;
  logic keypad_inhibit_o;
  logic panel_locked_o;
  logic remote_enabled_o;
  int fail_count = 0;
  int checks = 0;

  // Free-running 125 MHz clock
  always #4 ref_clk_i = ~ref_clk_i;

  // Short counts keep the run brief; the waits below are fixed cycle counts sized for them
  rci_far_end i_far (.ref_clk_i(ref_clk_i), .lines_n_o(lines_n));
  rci_remote_ctrl #(.DEB_CYC(8), .DEGAS_CYC(100)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce_i), .lines_n_i(lines_n),
    .filament_on_i(filament_on_i), .panel_i(panel_i), .grant_o(grant_o),
    .degas_start_o(pulses[P_START]), .degas_stop_o(pulses[P_STOP]),
    .fil_on_o(pulses[P_FON]), .fil_off_o(pulses[P_FOFF]), .log_clear_o(pulses[P_LOG]),
    .degas_active_o(degas_active_o), .fil_locked_o(fil_locked_o),
    .keypad_inhibit_o(keypad_inhibit_o), .panel_locked_o(panel_locked_o),
    .remote_enabled_o(remote_enabled_o)
  );

  task automatic cmp(input string nm, input logic [6:0] exp, input logic [6:0] got);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic flag(input string nm, input logic exp, input logic got);
    cmp(nm, {6'h0, exp}, {6'h0, got});
  endtask

  // Looks for one pulse in a window; a missed pulse and a stray one both count
  task automatic pulse(input int idx, input logic want, input int win, input string nm);
    logic hit;
    hit = 1'b0;
    repeat (win) @(negedge ref_clk_i) if (pulses[idx] === 1'b1) hit = 1'b1;
    flag(nm, want, hit);
  endtask

  task automatic idle();
    repeat (20) @(negedge ref_clk_i);
  endtask

  task automatic end_sim();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the roughly 1000 cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    fail_count++;
    end_sim();
  end

  // Main sequence, all stimulus on falling edges
  initial
  begin
    repeat (3) @(negedge ref_clk_i);
    rst_i = 1'b0;
    cmp("reset pulses", 7'h0, {2'h0, pulses});
    flag("remote enabled", 1'b0, remote_enabled_o);
    idle();
    cmp("grant idle", 7'h7f, grant_o);
    i_far.set_line(4, 1'b0);
    idle();
    flag("remote enabled", 1'b1, remote_enabled_o);
    filament_on_i = 1'b1;
    i_far.set_line(0, 1'b0);
    pulse(P_START, 1'b1, 40, "degas start");
    flag("degas active", 1'b1, degas_active_o);
    pulse(P_STOP, 1'b1, 100, "degas timeout");
    flag("degas active", 1'b0, degas_active_o);
    i_far.set_line(0, 1'b1);
    i_far.set_line(0, 1'b0);
    pulse(P_START, 1'b1, 40, "degas start");
    i_far.set_line(0, 1'b1);
    pulse(P_STOP, 1'b1, 30, "degas release");
    i_far.set_line(0, 1'b0);
    pulse(P_START, 1'b1, 40, "degas start");
    filament_on_i = 1'b0;
    pulse(P_STOP, 1'b1, 5, "degas fil off");
    i_far.set_line(0, 1'b1);
    i_far.set_line(0, 1'b0);
    pulse(P_START, 1'b0, 40, "degas no fil");
    i_far.set_line(0, 1'b1);
    i_far.set_line(5, 1'b0);
    pulse(P_FON, 1'b1, 40, "fil on");
    i_far.set_line(5, 1'b1);
    pulse(P_FOFF, 1'b1, 40, "fil off");
    i_far.glitch(5, 4);
    pulse(P_FON, 1'b0, 40, "fil glitch");
    // Gate high: filament edges are dropped, log clear still acts
    i_far.set_line(4, 1'b1);
    idle();
    i_far.set_line(5, 1'b0);
    pulse(P_FON, 1'b0, 40, "gated fil on");
    i_far.set_line(3, 1'b0);
    pulse(P_LOG, 1'b1, 40, "log clear");
    i_far.set_line(3, 1'b1);
    i_far.set_line(5, 1'b1);
    pulse(P_FOFF, 1'b0, 40, "gated fil off");
    i_far.set_line(4, 1'b0);
    idle();
    // Lockout acts only after the debounce time, ends degas and forces off in the same cycle
    filament_on_i = 1'b1;
    i_far.set_line(0, 1'b0);
    pulse(P_START, 1'b1, 40, "degas start");
    i_far.set_line(1, 1'b0);
    pulse(P_FOFF, 1'b0, 6, "lockout early");
    pulse(P_STOP, 1'b1, 40, "degas lockout");
    pulse(P_FOFF, 1'b1, 40, "lockout off");
    filament_on_i = 1'b0;
    idle();
    flag("fil locked", 1'b1, fil_locked_o);
    cmp("grant lockout", 7'h3e, grant_o);
    i_far.set_line(5, 1'b0);
    pulse(P_FON, 1'b0, 40, "locked fil on");
    i_far.set_line(5, 1'b1);
    i_far.set_line(1, 1'b1);
    idle();
    flag("fil locked", 1'b0, fil_locked_o);
    // Clock enable low freezes the filter, so the new level waits
    ce_i = 1'b0;
    i_far.set_line(2, 1'b0);
    idle();
    flag("keypad frozen", 1'b0, keypad_inhibit_o);
    ce_i = 1'b1;
    idle();
    flag("keypad inhibit", 1'b1, keypad_inhibit_o);
    cmp("grant keypad", 7'h2f, grant_o);
    i_far.set_line(2, 1'b1);
    i_far.set_line(6, 1'b0);
    idle();
    flag("panel locked", 1'b1, panel_locked_o);
    cmp("grant panel", 7'h01, grant_o);
    i_far.set_line(6, 1'b1);
    idle();
    cmp("grant free", 7'h7f, grant_o);
    panel_i = 7'h2a;
    idle();
    cmp("grant pattern", 7'h2a, grant_o);
    end_sim();
  end
endmodule

`default_nettype wire
